// file: design/sch_top.v
// Smart card host control: pin latching, card session sequencer,
// card clock divider and an AXI4-Lite register slave with interrupt.
// Assumes all host and card pins are asynchronous to aclk and that the
// oscillator input toggles slower than a quarter of aclk.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "sch_consts.vh"

// Behaviour
// RQ1: High on active-high detect means card present.
// RQ2: Low on active-low detect means card present.
// RQ3: Low supply request ramps supply, starts activation.
// RQ4: Voltage select high gives 5 V, low 3 V.
// RQ5: Unconnected voltage select defaults to 5 V.
// RQ6: Accepted sleep disables analog, lowest consumption.
// RQ7: Sleep ignored while supply request is low.
// RQ8: Selects 00 give /8, 01 give /4.
// RQ9: Crystal or external clock feeds the divider.
// RQ10: Only the sequencer switches the card supply.
// RQ11: Selects 11 give /2, 10 give undivided.
// RQ12: Chip select low freezes latched host inputs.
// RQ13: Sync mode copies the strobe to card clock.
// RQ14: Enabled card reset follows host reset input.
// RQ15: No activation without a detected card.
// RQ16: Host keeps selects stable during a session.
module sch_top #(
   parameter RAMP_NS  = `SCH_RAMP_NS,
   parameter DEACT_NS = `SCH_DEACT_NS
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        card_detect_active_high,
   input  wire        card_detect_active_low,
   input  wire        supply_on_request_n,
   input  wire        card_voltage_select,
   input  wire        sleep_request,
   input  wire        divider_select_first,
   input  wire        divider_select_second,
   input  wire        oscillator_input,
   input  wire        sync_mode_select,
   input  wire        strobe_input,
   input  wire        host_reset_input,
   input  wire        chip_select,
   output reg         card_supply_en,
   output reg         card_supply_5v,
   output reg         card_clock,
   output reg         card_reset,
   output reg         low_power_state,
   output reg         irq
);

   // ****************************************
   // Constants
   // ****************************************
   // Sequencer states.
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_RAMP  = 3'h1;
   localparam [2:0] ST_ACT   = 3'h2;
   localparam [2:0] ST_DEACT = 3'h3;
   localparam [2:0] ST_SLEEP = 3'h4;
   // Least times round up to whole cycles.
   localparam integer RAMP_CYC  = (RAMP_NS * `SCH_CLK_MHZ + 999) / 1000;
   localparam integer DEACT_CYC = (DEACT_NS * `SCH_CLK_MHZ + 999) / 1000;
   localparam integer NPIN = 12;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // All pins are asynchronous, so each passes two flops first.
   wire [NPIN-1:0] pin_raw;
   reg  [NPIN-1:0] pin_s1_ff;   // First stage, read only by stage two.
   reg  [NPIN-1:0] pin_s2_ff;   // Second stage, safe to use.
   // Reset value: voltage select defaults high, as its pull-up would.
   localparam [NPIN-1:0] PIN_RST = {1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, `SCH_VSEL_RST,
                                    1'h1, 1'h0};
   assign pin_raw = {chip_select, card_detect_active_low, host_reset_input, strobe_input, sync_mode_select,
                     oscillator_input, divider_select_second, divider_select_first, sleep_request,
                     card_voltage_select, supply_on_request_n, card_detect_active_high};
   // Two-stage synchroniser on every pin.
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_ff <= PIN_RST;
         pin_s2_ff <= PIN_RST;
      end else begin
         pin_s1_ff <= pin_raw;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // ****************************************
   // Host input latch
   // ****************************************
   // Held copies of the host controls, one below their pin index; bit 7 holds host reset.
   reg [7:0] hold_ff;
   wire      cs_s      = pin_s2_ff[11];
   wire      req_n     = hold_ff[0];
   wire      vsel      = hold_ff[1];
   wire      sleep_req = hold_ff[2];
   wire      div1      = hold_ff[3];
   wire      div2      = hold_ff[4];
   wire      sync_mode = hold_ff[6];
   wire      rst_in    = hold_ff[7];
   wire      osc_s     = pin_s2_ff[6];
   wire      strobe_s  = pin_s2_ff[8];
   // Controls follow the pins only while chip select is high.
   always @(posedge aclk) begin
      if (!aresetn) begin
         hold_ff <= {1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, `SCH_VSEL_RST, 1'h1};
      end else if (cs_s) begin
         hold_ff <= {pin_s2_ff[9], pin_s2_ff[7:1]}; // RQ12
      end
   end

   // ****************************************
   // Card presence
   // ****************************************
   reg  ctrl_det_low_ff;   // Software picks which detect input is wired.
   wire present = ctrl_det_low_ff ? ~pin_s2_ff[10] // RQ2
                                  : pin_s2_ff[0];  // RQ1
   reg  present_d_ff;      // Previous presence, for edge events.
   // ****************************************
   // Session sequencer
   // ****************************************
   reg [2:0]  state_ff;
   reg [2:0]  nxt_state;
   reg [15:0] tmr_ff;      // Counts ramp and wind-down cycles.
   reg [15:0] nxt_tmr;
   reg        ev_act;      // Pulses when the card becomes active.
   reg        ev_deact;    // Pulses when a wind-down completes.
   // Next state; sleep is only honoured outside a card session.
   always @* begin
      nxt_state = state_ff;
      nxt_tmr   = tmr_ff + 16'h1;
      ev_act    = 1'b0;
      ev_deact  = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            nxt_tmr = 16'h0;
            if (!req_n && present) nxt_state = ST_RAMP; // RQ3 RQ15
            else if (sleep_req && req_n) nxt_state = ST_SLEEP; // RQ7
         end
         ST_RAMP: begin
            // Losing the card or the request aborts the ramp.
            if (req_n || !present) begin
               nxt_state = ST_DEACT;
               nxt_tmr   = 16'h0;
            end else if (tmr_ff == RAMP_CYC[15:0] - 16'h1) begin
               nxt_state = ST_ACT;
               ev_act    = 1'b1;
            end
         end
         ST_ACT: begin
            nxt_tmr = 16'h0;
            // Card extraction forces an emergency wind-down.
            if (req_n || !present) nxt_state = ST_DEACT;
         end
         ST_DEACT: begin
            if (tmr_ff == DEACT_CYC[15:0] - 16'h1) begin
               nxt_state = ST_IDLE;
               ev_deact  = 1'b1;
            end
         end
         ST_SLEEP: begin
            nxt_tmr = 16'h0;
            // A session request wakes the part as well.
            if (!sleep_req || !req_n) nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_tmr   = 16'h0;
         end
      endcase
   end
   // State register.
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_IDLE;
         tmr_ff   <= 16'h0;
      end else begin
         state_ff <= nxt_state;
         tmr_ff   <= nxt_tmr;
      end
   end

   // ****************************************
   // Card clock divider
   // ****************************************
   // The oscillator is sampled, so it must stay well below aclk/4.
   reg       osc_d_ff;     // Delayed oscillator for edge detect.
   reg [1:0] div_cnt_ff;   // Rising edges seen in this half period.
   reg       div_clk_ff;   // Divided clock.
   reg [1:0] half_edges;   // Rising edges per half period, less one.
   wire      osc_rise = osc_s & ~osc_d_ff; // RQ9
   // Half period in oscillator edges, less one, for each divider setting.
   always @* begin
      case ({div2, div1})
         2'b00:   half_edges = 2'h3; // RQ8
         2'b10:   half_edges = 2'h1; // RQ8
         2'b11:   half_edges = 2'h0; // RQ11
         default: half_edges = 2'h0;
      endcase
   end
   // Toggle the divided clock after the chosen count of edges.
   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_d_ff   <= 1'b0;
         div_cnt_ff <= 2'h0;
         div_clk_ff <= 1'b0;
      end else begin
         osc_d_ff <= osc_s;
         if (osc_rise) begin
            // The count wraps on the same edge that flips the divided clock.
            div_cnt_ff <= (div_cnt_ff == half_edges) ? 2'h0 : div_cnt_ff + 2'h1;
            div_clk_ff <= div_clk_ff ^ (div_cnt_ff == half_edges);
         end
      end
   end

   // ****************************************
   // Card side outputs
   // ****************************************
   // Everything to the card is registered; all but card_supply_5v is gated by the sequencer.
   always @(posedge aclk) begin
      if (!aresetn) begin
         card_supply_en  <= 1'b0;
         card_supply_5v  <= `SCH_VSEL_RST;
         card_clock      <= 1'b0;
         card_reset      <= 1'b0;
         low_power_state <= 1'b0;
      end else begin
         card_supply_en  <= (state_ff == ST_RAMP) || (state_ff == ST_ACT); // RQ10
         card_supply_5v  <= vsel; // RQ4 RQ5
         low_power_state <= (state_ff == ST_SLEEP); // RQ6
         // Clock stays low outside the active state; sync mode wins over the divider.
         card_clock      <= (state_ff != ST_ACT) ? 1'b0 :
                            sync_mode ? strobe_s : // RQ13
                            ({div2, div1} == 2'b01) ? osc_d_ff : div_clk_ff; // RQ11
         card_reset <= (state_ff == ST_ACT) & rst_in; // RQ14
      end
   end

   // ****************************************
   // Interrupt status
   // ****************************************
   reg  [3:0] int_sts_ff;  // Sticky events, write one to clear.
   reg  [3:0] int_msk_ff;  // One enables the matching event.
   wire [3:0] int_set;
   wire [3:0] int_clr;
   assign int_set = {ev_deact, ev_act, present_d_ff & ~present, ~present_d_ff & present};
   // A set in the same cycle as its clear wins over the clear.
   always @(posedge aclk) begin
      if (!aresetn) begin
         int_sts_ff   <= `SCH_INT_RST;
         present_d_ff <= 1'b0;
         irq          <= 1'b0;
      end else begin
         present_d_ff <= present;
         int_sts_ff   <= (int_sts_ff & ~int_clr) | int_set;
         irq          <= |(int_sts_ff & int_msk_ff);
      end
   end

   // ****************************************
   // AXI4-Lite write channel
   // ****************************************
   reg  [3:0]  aw_addr_ff;  // Captured write address.
   reg         aw_have_ff;  // Address taken, waiting for data.
   reg  [31:0] w_data_ff;   // Captured write data.
   reg  [3:0]  w_strb_ff;
   reg         w_have_ff;   // Data taken, waiting for address.
   wire        do_write = aw_have_ff & w_have_ff & ~s_axi_bvalid;
   wire        wr_map   = (aw_addr_ff == `SCH_ADDR_CTRL) || (aw_addr_ff == `SCH_ADDR_STATUS) ||
                          (aw_addr_ff == `SCH_ADDR_INT_STS) || (aw_addr_ff == `SCH_ADDR_INT_MSK);
   assign int_clr = (do_write && aw_addr_ff == `SCH_ADDR_INT_STS && w_strb_ff[0]) ? w_data_ff[3:0] : 4'h0;
   // Address and data are taken independently, in either order.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff      <= 1'b0;
         w_have_ff       <= 1'b0;
         aw_addr_ff      <= 4'h0;
         w_data_ff       <= 32'h0;
         w_strb_ff       <= 4'h0;
         s_axi_awready   <= 1'b0;
         s_axi_wready    <= 1'b0;
         s_axi_bvalid    <= 1'b0;
         s_axi_bresp     <= `SCH_RESP_OKAY;
         ctrl_det_low_ff <= `SCH_CTRL_RST;
         int_msk_ff      <= `SCH_INT_RST;
      end else begin
         s_axi_awready <= ~aw_have_ff & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready  <= ~w_have_ff & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_ff <= 1'b1;
            aw_addr_ff <= {s_axi_awaddr[3:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_ff   <= 1'b0;
            w_have_ff    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `SCH_RESP_OKAY : `SCH_RESP_SLVERR;
            if (aw_addr_ff == `SCH_ADDR_CTRL && w_strb_ff[0]) ctrl_det_low_ff <= w_data_ff[`SCH_CTRL_DET_LOW];
            if (aw_addr_ff == `SCH_ADDR_INT_MSK && w_strb_ff[0]) int_msk_ff <= w_data_ff[3:0];
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   reg [31:0] rd_word;     // Word selected by the read address.
   reg        rd_map;      // Read address is mapped.
   // Read mux; status shows presence, session state and modes.
   always @* begin
      rd_map  = 1'b1;
      rd_word = 32'h0;
      case ({s_axi_araddr[3:2], 2'h0})
         `SCH_ADDR_CTRL:    rd_word = {31'h0, ctrl_det_low_ff};
         `SCH_ADDR_STATUS:  rd_word = {24'h0, low_power_state, vsel, sync_mode, state_ff, card_supply_en,
                                       present};
         `SCH_ADDR_INT_STS: rd_word = {28'h0, int_sts_ff};
         `SCH_ADDR_INT_MSK: rd_word = {28'h0, int_msk_ff};
         default:           rd_map  = 1'b0;
      endcase
   end
   // One read at a time; the answer stands until rready.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `SCH_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_map ? `SCH_RESP_OKAY : `SCH_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // sch_top

// file: include/sch_consts.vh
// Constants for the smart card host control block.
// Assumes a 250 MHz aclk and a 32-bit AXI4-Lite register bus.
`ifndef SCH_CONSTS_VH
`define SCH_CONSTS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define SCH_ADDR_CTRL    4'h0
`define SCH_ADDR_STATUS  4'h4
`define SCH_ADDR_INT_STS 4'h8
`define SCH_ADDR_INT_MSK 4'hc

// ****************************************
// Field positions
// ****************************************
`define SCH_CTRL_DET_LOW  0
`define SCH_INT_INSERT    0
`define SCH_INT_REMOVE    1
`define SCH_INT_ACT_DONE  2
`define SCH_INT_DEACT_END 3
`define SCH_INT_BITS      4

// ****************************************
// Reset values
// ****************************************
`define SCH_CTRL_RST    1'h0
`define SCH_INT_RST     4'h0
`define SCH_VSEL_RST    1'h1

// ****************************************
// AXI responses
// ****************************************
`define SCH_RESP_OKAY   2'h0
`define SCH_RESP_SLVERR 2'h2

// ****************************************
// Timing
// ****************************************
`define SCH_CLK_MHZ     250
`define SCH_RAMP_NS     1000
`define SCH_DEACT_NS    400
`define SCH_RAMP_CYC    ((`SCH_RAMP_NS * `SCH_CLK_MHZ + 999) / 1000)
`define SCH_DEACT_CYC   ((`SCH_DEACT_NS * `SCH_CLK_MHZ + 999) / 1000)

`endif

// file: test/sch_top_props.sv
// Checker for the smart card host control block, bound to sch_top.
// Assumes the single aclk domain with the synchronous active-low aresetn.
`timescale 1ns/1ps
`include "sch_consts.vh"
module sch_top_props (
   input wire       aclk,
   input wire       aresetn,
   input wire       s_axi_awvalid,
   input wire       s_axi_awready,
   input wire       s_axi_wvalid,
   input wire       s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire       s_axi_bvalid,
   input wire       s_axi_bready,
   input wire       s_axi_arvalid,
   input wire       s_axi_arready,
   input wire       s_axi_rvalid,
   input wire       s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire       supply_on_request_n,
   input wire       sleep_request,
   input wire       card_supply_en,
   input wire       card_clock,
   input wire       card_reset,
   input wire       low_power_state
);
   // ****************************************
   // Properties
   // ****************************************
   // One domain only, so clock and reset are given once for all assertions.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response latency wrong");
   AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data latency wrong");
   AST_AW_GAP: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("address ready did not drop");
   AST_RESP_CODE: assert property (s_axi_bvalid |-> s_axi_bresp == `SCH_RESP_OKAY || s_axi_bresp == `SCH_RESP_SLVERR)
      else $error("illegal write response");
   AST_CARD_IDLE: assert property (!card_supply_en |-> !card_clock && !card_reset)
      else $error("card clock or reset live without supply");
   AST_SLEEP_OFF: assert property (low_power_state |-> !card_supply_en)
      else $error("supply on during sleep");
   AST_SLEEP_ENTRY: assert property ($rose(low_power_state) |-> $past(sleep_request, 5) && $past(supply_on_request_n, 5))
      else $error("sleep entered without a valid request");
endmodule // sch_top_props
bind sch_top sch_top_props u_props (.*);

// file: test/sch_far_model.sv
// Far-side model: oscillator source and synchronous-card strobe.
// Assumes the bench's aclk; both sources change just after its rising edge.
`timescale 1ns/1ps
module sch_far_model (
   input  wire aclk,
   input  wire aresetn,
   output reg  oscillator_input,
   output reg  strobe_input
);
   reg [3:0] osc_cnt_ff; // Oscillator half period of 8 aclk keeps edges far apart.
   reg [3:0] stb_cnt_ff; // Strobe half period of 10 aclk differs from every divider rate.
   initial begin
      oscillator_input = 1'b0;
      strobe_input = 1'b0;
      osc_cnt_ff = 4'h0;
      stb_cnt_ff = 4'h0;
   end
   // An external clock source stands in for the crystal; both must work the same.
   always @(posedge aclk) begin
      osc_cnt_ff <= (osc_cnt_ff == 4'h7) ? 4'h0 : osc_cnt_ff + 4'h1;
      stb_cnt_ff <= (stb_cnt_ff == 4'h9) ? 4'h0 : stb_cnt_ff + 4'h1;
      if (osc_cnt_ff == 4'h7) oscillator_input <= !oscillator_input;
      if (stb_cnt_ff == 4'h9) strobe_input <= !strobe_input;
   end
endmodule // sch_far_model

// file: test/tb_top.sv
// Self-checking bench for sch_top: AXI4-Lite tasks plus pin-level sessions.
// Assumes short ramp and deactivation parameters to keep sessions brief.
`timescale 1ns/1ps
`include "sch_consts.vh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
   $display("FAIL %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
   localparam int RAMP_P = 20;
   localparam int DEACT_P = 20;
   localparam int RAMP_CYC = (RAMP_P * `SCH_CLK_MHZ + 999) / 1000;
   localparam int DEACT_CYC = (DEACT_P * `SCH_CLK_MHZ + 999) / 1000;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, card_supply_en, card_supply_5v, card_clock, card_reset;
   logic low_power_state, irq, oscillator_input, strobe_input;
   logic [3:0] s_axi_awaddr = 0, s_axi_wstrb = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic card_detect_active_high = 0, card_detect_active_low = 1, supply_on_request_n = 1;
   logic card_voltage_select = 1, sleep_request = 0, divider_select_first = 0;
   logic divider_select_second = 0, sync_mode_select = 0, host_reset_input = 0, chip_select = 1;
   int err_total = 0, tests_run = 0, cycles = 0, n, m;
   logic prev;
   logic [2:0] mode_tbl [5] = '{3'b000, 3'b010, 3'b011, 3'b001, 3'b100}; // {sync, second, first}
   int rise_tbl [5] = '{4, 8, 16, 32, 26}; // Card clock rises in 512 aclk.
   sch_top #(.RAMP_NS(RAMP_P), .DEACT_NS(DEACT_P)) dut (.*);
   sch_far_model u_far (.aclk(aclk), .aresetn(aresetn), .oscillator_input(oscillator_input),
      .strobe_input(strobe_input));
   // ****************************************
   // Clock, watchdog and verdict
   // ****************************************
   initial forever #2 aclk = !aclk;
   // A hang is cut short well above the few thousand cycles the run needs.
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         end_of_test();
      end
   end
   task end_of_test;
      if (err_total == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ****************************************
   // Bus and session tasks
   // ****************************************
   // Address and data are offered together and each dropped once taken.
   task axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_p, w_p;
      aw_p = 1;
      w_p = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge aclk);
         if (aw_p && s_axi_awready) begin
            aw_p = 0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_p && s_axi_wready) begin
            w_p = 0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, er)
      @(posedge aclk); // An edge passes so a following call never re-drives bready in this step.
   endtask
   task axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      `CHK(s_axi_rdata, ed)
      `CHK(s_axi_rresp, er)
      @(posedge aclk); // An edge passes so a following call never re-drives rready in this step.
   endtask
   task session_on;
      supply_on_request_n <= 1'b0;
      n = 0;
      while (card_supply_en !== 1'b1 && n < 40) begin
         @(posedge aclk);
         n++;
      end
      `CHK(card_supply_en, 1'b1)
      repeat (RAMP_CYC + 4) @(posedge aclk);
   endtask
   task session_off;
      supply_on_request_n <= 1'b1;
      repeat (DEACT_CYC + 20) @(posedge aclk);
      `CHK(card_supply_en, 1'b0)
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      `CHK(card_supply_5v, 1'b1)
      axi_read(`SCH_ADDR_STATUS, 32'h40, `SCH_RESP_OKAY);
      axi_read(4'h2, 32'h0, `SCH_RESP_OKAY); // Low address bits are ignored: this aliases the control word.
      supply_on_request_n <= 1'b0;
      repeat (30) @(posedge aclk);
      `CHK(card_supply_en, 1'b0)
      supply_on_request_n <= 1'b1;
      axi_write(`SCH_ADDR_INT_MSK, 32'h1, `SCH_RESP_OKAY);
      card_detect_active_high <= 1'b1;
      repeat (10) @(posedge aclk);
      `CHK(irq, 1'b1)
      axi_read(`SCH_ADDR_INT_STS, 32'h1, `SCH_RESP_OKAY);
      axi_write(`SCH_ADDR_INT_MSK, 32'h0, `SCH_RESP_OKAY);
      repeat (3) @(posedge aclk);
      `CHK(irq, 1'b0)
      axi_write(`SCH_ADDR_INT_STS, 32'h1, `SCH_RESP_OKAY);
      axi_write(`SCH_ADDR_INT_MSK, 32'hf, `SCH_RESP_OKAY);
      repeat (3) @(posedge aclk);
      `CHK(irq, 1'b0)
      // Every divider rate and the strobe copy, each in a session of its own.
      for (m = 0; m < 5; m++) begin
         {sync_mode_select, divider_select_second, divider_select_first} <= mode_tbl[m];
         card_voltage_select <= m[0];
         @(posedge aclk);
         session_on();
         axi_read(`SCH_ADDR_STATUS, {24'h0, 1'b0, m[0], mode_tbl[m][2], 5'h0b}, `SCH_RESP_OKAY);
         `CHK(card_supply_5v, m[0])
         n = 0;
         prev = card_clock;
         repeat (512) begin
            @(posedge aclk);
            if (card_clock && !prev) n++;
            prev = card_clock;
         end
         `CHK(n >= rise_tbl[m] - 1 && n <= rise_tbl[m] + 1, 1'b1)
         host_reset_input <= 1'b1;
         repeat (8) @(posedge aclk);
         `CHK(card_reset, 1'b1)
         host_reset_input <= 1'b0;
         repeat (8) @(posedge aclk);
         `CHK(card_reset, 1'b0)
         session_off();
      end
      axi_write(`SCH_ADDR_CTRL, 32'h1, `SCH_RESP_OKAY);
      card_detect_active_high <= 1'b0;
      card_detect_active_low <= 1'b0;
      session_on();
      axi_write(`SCH_ADDR_INT_STS, 32'hf, `SCH_RESP_OKAY);
      card_detect_active_low <= 1'b1;
      repeat (DEACT_CYC + 20) @(posedge aclk);
      `CHK(card_supply_en, 1'b0)
      axi_read(`SCH_ADDR_INT_STS, 32'ha, `SCH_RESP_OKAY);
      supply_on_request_n <= 1'b1;
      sleep_request <= 1'b1;
      repeat (12) @(posedge aclk);
      `CHK(low_power_state, 1'b1)
      sleep_request <= 1'b0;
      supply_on_request_n <= 1'b0;
      repeat (12) @(posedge aclk);
      sleep_request <= 1'b1;
      repeat (12) @(posedge aclk);
      `CHK(low_power_state, 1'b0)
      sleep_request <= 1'b0;
      supply_on_request_n <= 1'b1;
      card_detect_active_low <= 1'b0;
      repeat (12) @(posedge aclk);
      chip_select <= 1'b0;
      repeat (4) @(posedge aclk);
      supply_on_request_n <= 1'b0;
      repeat (30) @(posedge aclk);
      `CHK(card_supply_en, 1'b0)
      chip_select <= 1'b1;
      session_on();
      session_off();
      end_of_test();
   end
endmodule // tb_top
